// ===== hw/cfw_top.sv
`timescale 1ns/10ps
// Contract
// - Waveform samples are signed 24-bit words, at most one per 160 clocks.
// - Two-bit rate field picks 25.6, 12.8, 6.4 or 3.2 kSPS; code gives 250, 125, 62.5 or 31.25 kSPS at 40 MHz.
// - New sample with its enable set raises pending metering interrupt.
// - Reading a waveform high byte latches the selected samples.
// - New-sample interrupt holds until software clears its status bit.
// - Power computation continues uninterrupted during waveform sampling.
// - Inputs faulted when difference exceeds 6.25 percent of active input.
// - On fault with larger inactive input, switch measurement to it.
// - After reset, the first current input is used.
// - Inputs are averaged; fault reported about one second after onset.
// - Fault detection suspended while voltage is below 0.3 percent.
// - Accumulation mode bit 7 reports measured input, updated on switching.
// - Forced field 01 first input, 10 second, 00/11 automatic.
// - Mode bit 6 clear: fault-sign flag set entering fault or normal.
// - Fault-sign flag with enable bit 5 raises pending interrupt.
// - First active, second below 93.75 percent: flag set, no swap.
// - Fault-sign indication averaged, appearing about three seconds later.
// - Return to first input needs first above second by 6.25 percent.
// - Mode bit 6 set: flag set when first comes within 6.25 percent.
module cfw_top #(
    parameter int FAULT_AVG_CYC = cfw_pkg::FAULT_AVG_CYC,
    parameter int SIGN_AVG_CYC = cfw_pkg::SIGN_AVG_CYC,
    parameter int BASE_DIV = cfw_pkg::BASE_DIV,
    parameter logic [23:0] V_MIN = 24'h001935
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Sample inputs, signed 24-bit words; magnitudes are their absolute values
    input wire logic [23:0] first_current_input,
    input wire logic [23:0] second_current_input,
    input wire logic [23:0] voltage_sample,
    // Measurement routing and interrupt
    output logic [23:0] measured_current,
    output logic irq
);
    ////////////////////////////////////////////////////////////////////////
    logic [7:0] waveform_mode_register_reg;
    logic [7:0] accumulation_mode_register_reg;
    logic [7:0] calibration_mode_register_reg;
    logic [7:0] irqen1_reg;
    logic [7:0] irqen3_reg;
    logic fsign_flag_reg;
    logic new_sample_flag_reg;
    logic [23:0] wav1_reg;
    logic [23:0] wav2_reg;
    logic [7:0] div_reg;
    logic [2:0] dec_reg;
    logic sample_tick;
    logic wr_acc;
    logic rd_acc;
    logic clr_fsign;
    logic clr_new;
    logic [1:0] rate;
    logic [2:0] dec_max;
    logic [31:0] fcnt_reg;
    logic [31:0] scnt_reg;
    logic sel_second_reg;
    logic fault_seen;
    logic sign_cond_reg;
    logic [23:0] a_abs;
    logic [23:0] b_abs;
    logic [23:0] v_abs;
    logic [23:0] act;
    logic [23:0] inact;
    logic fault_now;
    logic swap_cond;
    logic sign_now;
    logic auto_sel;

    ////////////////////////////////////////////////////////////////////////
    // APB decode; zero wait states
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign clr_fsign = wr_acc && paddr == cfw_pkg::ADDR_IRQST1
        && pwdata[cfw_pkg::FSIGN_BIT];
    assign clr_new = wr_acc && paddr == cfw_pkg::ADDR_IRQST3
        && pwdata[cfw_pkg::NEW_SAMPLE_BIT];

    // Software registers; bit 7 of accumulation mode is hardware owned
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            waveform_mode_register_reg <= cfw_pkg::WAVEFORM_MODE_REGISTER_RST;
            accumulation_mode_register_reg <= cfw_pkg::ACCUMULATION_MODE_REGISTER_RST;
            calibration_mode_register_reg <= cfw_pkg::CALIBRATION_MODE_REGISTER_RST;
            irqen1_reg <= cfw_pkg::IRQEN_RST;
            irqen3_reg <= cfw_pkg::IRQEN_RST;
        end
        else if (wr_acc)
        begin
            case (paddr)
                cfw_pkg::ADDR_WAVEFORM_MODE_REGISTER: waveform_mode_register_reg <= pwdata[7:0];
                cfw_pkg::ADDR_ACCUMULATION_MODE_REGISTER: accumulation_mode_register_reg <= {1'b0, pwdata[6:0]};
                cfw_pkg::ADDR_CALIBRATION_MODE_REGISTER: calibration_mode_register_reg <= pwdata[7:0];
                cfw_pkg::ADDR_IRQEN1: irqen1_reg <= {2'b00, pwdata[5:0]};
                cfw_pkg::ADDR_IRQEN3: irqen3_reg <= {2'b00, pwdata[5:0]};
                default: ;
            endcase
        end
    end

    // Read mux; unmapped addresses read zero, and only unmapped reads flag an error
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            if (psel && !penable)
            begin
                case (paddr)
                    cfw_pkg::ADDR_WAVEFORM_MODE_REGISTER: prdata <= {24'h0, waveform_mode_register_reg};
                    cfw_pkg::ADDR_ACCUMULATION_MODE_REGISTER:
                        prdata <= {24'h0, sel_second_reg, accumulation_mode_register_reg[6:0]};
                    cfw_pkg::ADDR_CALIBRATION_MODE_REGISTER: prdata <= {24'h0, calibration_mode_register_reg};
                    cfw_pkg::ADDR_IRQEN1: prdata <= {24'h0, irqen1_reg};
                    cfw_pkg::ADDR_IRQEN3: prdata <= {24'h0, irqen3_reg};
                    cfw_pkg::ADDR_IRQST1:
                        prdata <= {26'h0, fsign_flag_reg, 5'h00};
                    cfw_pkg::ADDR_IRQST3:
                        prdata <= {26'h0, new_sample_flag_reg, 5'h00};
                    cfw_pkg::ADDR_WAV1: prdata <= {{8{wav1_reg[23]}}, wav1_reg};
                    cfw_pkg::ADDR_WAV2: prdata <= {{8{wav2_reg[23]}}, wav2_reg};
                    cfw_pkg::ADDR_WAVEFORM1_HIGH_BYTE: prdata <= {24'h0, wav1_reg[23:16]};
                    cfw_pkg::ADDR_WAVEFORM2_HIGH_BYTE: prdata <= {24'h0, wav2_reg[23:16]};
                    default: pslverr <= !pwrite;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sample rate: base tick every BASE_DIV clocks, decimated by 1,2,4,8
    assign rate = waveform_mode_register_reg[cfw_pkg::RATE_LSB +: 2];
    assign dec_max = 3'((4'd1 << rate) - 4'd1);
    assign sample_tick = div_reg == 8'(BASE_DIV - 1) && dec_reg >= dec_max;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            div_reg <= 8'h00;
            dec_reg <= 3'h0;
        end
        else if (div_reg == 8'(BASE_DIV - 1))
        begin
            div_reg <= 8'h00;
            dec_reg <= (dec_reg >= dec_max) ? 3'h0 : dec_reg + 3'h1;
        end
        else
        begin
            div_reg <= div_reg + 8'h01;
        end
    end

    // Latch on high-byte read; samples never stall measurement path
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wav1_reg <= 24'h000000;
            wav2_reg <= 24'h000000;
        end
        else if (rd_acc && (paddr == cfw_pkg::ADDR_WAVEFORM1_HIGH_BYTE
            || paddr == cfw_pkg::ADDR_WAVEFORM2_HIGH_BYTE))
        begin
            wav1_reg <= sel_second_reg ? second_current_input
                : first_current_input;
            wav2_reg <= voltage_sample;
        end
    end

    // New-sample flag: set wins over clear
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            new_sample_flag_reg <= 1'b0;
        else if (sample_tick)
            new_sample_flag_reg <= 1'b1;
        else if (clr_new)
            new_sample_flag_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Magnitudes and thresholds (x - x/16 is 93.75 percent)
    assign a_abs = first_current_input[23] ? -first_current_input
        : first_current_input;
    assign b_abs = second_current_input[23] ? -second_current_input
        : second_current_input;
    assign v_abs = voltage_sample[23] ? -voltage_sample : voltage_sample;
    assign act = sel_second_reg ? b_abs : a_abs;
    assign inact = sel_second_reg ? a_abs : b_abs;
    assign fault_now = v_abs >= V_MIN
        && (inact > act + (act >> 4) || inact < act - (act >> 4));
    // Larger inactive beyond 6.25 percent of the active input
    assign swap_cond = sel_second_reg ? (a_abs > b_abs + (b_abs >> 4))
        : (b_abs > a_abs + (a_abs >> 4));
    // Sign condition: mode 0 tracks fault, mode 1 within 6.25 percent
    assign sign_now = accumulation_mode_register_reg[cfw_pkg::FSIGN_MODE_BIT]
        ? (a_abs + (b_abs >> 4) >= b_abs)
        : (!sel_second_reg && b_abs < a_abs - (a_abs >> 4)) || fault_now;
    assign auto_sel = calibration_mode_register_reg[cfw_pkg::FORCED_LSB +: 2]
        == cfw_pkg::CFW_FORCE_AUTO0
        || calibration_mode_register_reg[cfw_pkg::FORCED_LSB +: 2] == cfw_pkg::CFW_FORCE_AUTO1;

    // Persistence counter: a fault must hold ~1 s before a swap
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fcnt_reg <= 32'h00000000;
        else if (!(fault_now && swap_cond))
            fcnt_reg <= 32'h00000000;
        else if (fcnt_reg < 32'(FAULT_AVG_CYC))
            fcnt_reg <= fcnt_reg + 32'h00000001;
    end

    // Channel selection; reset starts on the first input
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            sel_second_reg <= 1'b0;
        else if (calibration_mode_register_reg[cfw_pkg::FORCED_LSB +: 2]
            == cfw_pkg::CFW_FORCE_FIRST)
            sel_second_reg <= 1'b0;
        else if (calibration_mode_register_reg[cfw_pkg::FORCED_LSB +: 2]
            == cfw_pkg::CFW_FORCE_SECOND)
            sel_second_reg <= 1'b1;
        // Condition rechecked, so a saturated count cannot flip back at once
        else if (auto_sel && fault_now && swap_cond
            && fcnt_reg == 32'(FAULT_AVG_CYC))
            sel_second_reg <= !sel_second_reg;
    end

    // Sign indication: condition change must persist ~3 s
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            scnt_reg <= 32'h00000000;
            sign_cond_reg <= 1'b0;
        end
        else if (sign_now == sign_cond_reg || v_abs < V_MIN)
            scnt_reg <= 32'h00000000;
        else if (scnt_reg == 32'(SIGN_AVG_CYC))
        begin
            scnt_reg <= 32'h00000000;
            sign_cond_reg <= sign_now;
        end
        else
            scnt_reg <= scnt_reg + 32'h00000001;
    end

    // Flag on entering fault or normal (mode 0) or entering window (mode 1)
    assign fault_seen = scnt_reg == 32'(SIGN_AVG_CYC)
        && (!accumulation_mode_register_reg[cfw_pkg::FSIGN_MODE_BIT] || sign_now);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            fsign_flag_reg <= 1'b0;
        else if (fault_seen)
            fsign_flag_reg <= 1'b1;
        else if (clr_fsign)
            fsign_flag_reg <= 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs; measurement routing never paused by waveform reads
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            measured_current <= 24'h000000;
            irq <= 1'b0;
        end
        else
        begin
            measured_current <= sel_second_reg ? second_current_input
                : first_current_input;
            irq <= (new_sample_flag_reg && irqen3_reg[cfw_pkg::NEW_SAMPLE_BIT])
                || (fsign_flag_reg && irqen1_reg[cfw_pkg::FSIGN_BIT]);
        end
    end
endmodule

// ===== inc/cfw_pkg.sv
package cfw_pkg;
    // Register byte addresses on APB (one aligned word each)
    localparam logic [7:0] ADDR_WAVEFORM_MODE_REGISTER = 8'h00; // waveform_mode_register
    localparam logic [7:0] ADDR_ACCUMULATION_MODE_REGISTER = 8'h04; // accumulation_mode_register
    localparam logic [7:0] ADDR_CALIBRATION_MODE_REGISTER = 8'h08; // calibration_mode_register
    localparam logic [7:0] ADDR_IRQEN1 = 8'h0C; // interrupt_enable_one
    localparam logic [7:0] ADDR_IRQEN3 = 8'h10; // interrupt_enable_three
    localparam logic [7:0] ADDR_IRQST1 = 8'h14; // interrupt_status_one
    localparam logic [7:0] ADDR_IRQST3 = 8'h18; // interrupt_status_three
    localparam logic [7:0] ADDR_WAV1 = 8'h1C; // waveform 1 word
    localparam logic [7:0] ADDR_WAV2 = 8'h20; // waveform 2 word
    localparam logic [7:0] ADDR_WAVEFORM1_HIGH_BYTE = 8'h24; // waveform1_high_byte
    localparam logic [7:0] ADDR_WAVEFORM2_HIGH_BYTE = 8'h28; // waveform2_high_byte
    // Field positions
    localparam int RATE_LSB = 0;
    localparam int SEL_INPUT_BIT = 7;
    localparam int FSIGN_MODE_BIT = 6;
    localparam int FORCED_LSB = 4;
    localparam int FSIGN_BIT = 5;
    localparam int NEW_SAMPLE_BIT = 5;
    // Reset values
    localparam logic [7:0] WAVEFORM_MODE_REGISTER_RST = 8'h00;
    localparam logic [7:0] ACCUMULATION_MODE_REGISTER_RST = 8'h00;
    localparam logic [7:0] CALIBRATION_MODE_REGISTER_RST = 8'h00;
    localparam logic [7:0] IRQEN_RST = 8'h00;
    // Timing: base sample period in metering clocks, then averaging windows
    localparam int BASE_DIV = 160;
    localparam int CLK_HZ = 40000000;
    localparam int FAULT_AVG_MS = 1000;
    localparam int SIGN_AVG_MS = 3000;
    localparam int FAULT_AVG_CYC = CLK_HZ / 1000 * FAULT_AVG_MS;
    localparam int SIGN_AVG_CYC = CLK_HZ / 1000 * SIGN_AVG_MS;
    // Forced input field encodings
    typedef enum logic [1:0]
    {
        CFW_FORCE_AUTO0 = 2'b00,
        CFW_FORCE_FIRST = 2'b01,
        CFW_FORCE_SECOND = 2'b10,
        CFW_FORCE_AUTO1 = 2'b11
    } cfw_force_e;
endpackage

// ===== dv/cfw_top_chk.sv
`timescale 1ns/10ps
// Bus and routing watcher for the metering front-end
module cfw_top_chk #(
    parameter int FAULT_AVG_CYC = 20,
    parameter int SIGN_AVG_CYC = 40,
    parameter int BASE_DIV = 160,
    parameter logic [23:0] V_MIN = 24'h001935
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Samples and results
    input wire logic [23:0] first_current_input,
    input wire logic [23:0] second_current_input,
    input wire logic [23:0] voltage_sample,
    input wire logic [23:0] measured_current,
    input wire logic irq
);
    logic wr_acc;
    logic [1:0] force_q;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////////
    // Access edge of a write, where register updates land
    assign wr_acc = psel && penable && pwrite && pready;
    // Bus-side shadow of the forced field; avoids peeking inside the design
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            force_q <= 2'b00;
        else if (wr_acc && paddr == cfw_pkg::ADDR_CALIBRATION_MODE_REGISTER)
            force_q <= pwdata[5:4];
    end
    // Field held for three edges, so selection latency has settled
    property p_forced(logic [1:0] code, logic [23:0] src);
        force_q == code && $past(force_q) == code && $past(force_q, 2) == code
            |-> measured_current == $past(src);
    endproperty
    ////////////////////////////////////////////////////////////////////////////
    chk_ready_setup: assert property (psel && !penable |=> pready)
        else $error("pready missing after setup");
    chk_ready_single: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_ready_cause: assert property (pready |-> $past(psel && !penable))
        else $error("pready without setup");
    chk_err_ready: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    chk_unmapped_read: assert property (psel && !penable && !pwrite &&
        paddr > cfw_pkg::ADDR_WAVEFORM2_HIGH_BYTE |=> pslverr && prdata == 32'h0)
        else $error("unmapped read not refused");
    chk_irq_clear: assert property ($fell(irq) |->
        $past(wr_acc) || $past(wr_acc, 2))
        else $error("irq dropped without a write");
    chk_force_first: assert property (p_forced(2'b01,
        first_current_input))
        else $error("forced first input not measured");
    chk_force_second: assert property (p_forced(2'b10,
        second_current_input))
        else $error("forced second input not measured");
    chk_meas_source: assert property ($past(presetn, 3) |->
        measured_current == $past(first_current_input) ||
        measured_current == $past(second_current_input))
        else $error("measured current is neither input");
    // Main scenarios
    cover property (pready && pslverr);
    cover property ($rose(irq));
    cover property ($changed(measured_current));
endmodule

// ===== dv/cfw_apb_mst.sv
`timescale 1ns/10ps
// Metering core stand-in: plain APB master, one transfer at a time
module cfw_apb_mst
(
    // Clock
    input wire logic pclk,
    // Request
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    // Answer
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle bus from time zero
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // Request held until pready is seen at an edge; answer taken there
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic err,
        output logic tmo);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 64);
        q = prdata;
        err = pslverr;
        tmo = n >= 64;
        psel <= 1'b0;
        penable <= 1'b0;
        // Released data flips, so a stale value never looks valid
        pwdata <= ~d;
    endtask
endmodule

// ===== dv/cfw_top_tb.sv
`timescale 1ns/10ps
module cfw_top_tb;
    localparam int FAV = 20;
    localparam int SAV = 40;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er, to;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [23:0] ia, ib, vs, meas;
    int num_errors, comparisons;
    int cyc = 0;
    // Short averaging windows keep the run brief
    cfw_top #(.FAULT_AVG_CYC(FAV), .SIGN_AVG_CYC(SAV)) cfw_top_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .first_current_input(ia),
        .second_current_input(ib), .voltage_sample(vs),
        .measured_current(meas), .irq(irq));
    cfw_apb_mst cfw_apb_mst_i (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    ////////////////////////////////////////////////////////////////////////////
    // Clock and edge counter
    initial
    begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk) cyc <= cyc + 1;
    task automatic final_report(input logic hung);
        if (hung)
            num_errors++;
        $display("errors %0d comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        comparisons++;
        if (g !== e)
        begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [31:0] d);
        cfw_apb_mst_i.xfer(w, a, d, rd, er, to);
        if (to)
            final_report(1'b1);
    endtask
    task automatic rdm(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), e, rd & m);
    endtask
    // Bounded wait on measured current (sel) or on irq
    task automatic wait_for(input logic sel, input logic [23:0] e,
        input int lim);
        int n;
        n = 0;
        while ((sel ? meas !== e : irq !== e[0]) && n < lim)
        begin
            @(posedge pclk);
            n++;
        end
        if (n >= lim)
            final_report(1'b1);
    endtask
    task automatic clr3;
        bus(1'b1, cfw_pkg::ADDR_IRQST3, 32'h20);
        wait_for(1'b0, 24'h0, 8);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        for (int i = 0; i < 5; i++)
            rdm(cfw_pkg::ADDR_WAVEFORM_MODE_REGISTER + 8'(4 * i), 32'hFFFFFFFF, 32'h0);
        bus(1'b0, 8'h40, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, er});
        chk("unmapped data", 32'h0, rd);
    endtask
    // First tick after a rate change may be short, so it is discarded
    task automatic t_rate;
        int t;
        bus(1'b1, cfw_pkg::ADDR_IRQEN3, 32'h20);
        for (int r = 0; r < 4; r++)
        begin
            bus(1'b1, cfw_pkg::ADDR_WAVEFORM_MODE_REGISTER, 32'(r));
            clr3();
            wait_for(1'b0, 24'h1, 3000);
            clr3();
            wait_for(1'b0, 24'h1, 3000);
            t = cyc;
            repeat (20) @(posedge pclk);
            chk("irq held", 32'h1, {31'h0, irq});
            clr3();
            wait_for(1'b0, 24'h1, 3000);
            chk("period", 32'(cfw_pkg::BASE_DIV << r), 32'(cyc - t));
        end
        bus(1'b1, cfw_pkg::ADDR_IRQEN3, 32'h0);
        clr3();
        repeat (1400) @(posedge pclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        rdm(cfw_pkg::ADDR_IRQST3, 32'h20, 32'h20);
        bus(1'b1, cfw_pkg::ADDR_WAVEFORM_MODE_REGISTER, 32'h0);
    endtask
    task automatic t_latch;
        ia <= 24'h123456;
        ib <= 24'h120000;
        vs <= 24'hF00001;
        repeat (4) @(posedge pclk);
        bus(1'b0, cfw_pkg::ADDR_WAVEFORM1_HIGH_BYTE, 32'h0);
        ia <= 24'h123400;
        rdm(cfw_pkg::ADDR_WAV1, 32'hFFFFFFFF, 32'h00123456);
        rdm(cfw_pkg::ADDR_WAV2, 32'hFFFFFFFF, 32'hFFF00001);
    endtask
    task automatic t_force;
        for (int f = 0; f < 4; f++)
        begin
            bus(1'b1, cfw_pkg::ADDR_CALIBRATION_MODE_REGISTER, 32'(f << 4));
            repeat (4) @(posedge pclk);
            // Code 11 is automatic and keeps the forced second input
            chk("measured", f >= 2 ? ib : ia, meas);
            rdm(cfw_pkg::ADDR_ACCUMULATION_MODE_REGISTER, 32'h80, f >= 2 ? 32'h80 : 32'h0);
        end
        // Park on the first input before returning to automatic choice
        bus(1'b1, cfw_pkg::ADDR_CALIBRATION_MODE_REGISTER, 32'h10);
        bus(1'b1, cfw_pkg::ADDR_CALIBRATION_MODE_REGISTER, 32'h0);
        repeat (2) @(posedge pclk);
        chk("measured", ia, meas);
    endtask
    task automatic t_fault;
        ia <= 24'h100000;
        ib <= 24'h140000;
        vs <= 24'h000010;
        repeat (FAV * 5) @(posedge pclk);
        chk("measured", ia, meas);
        vs <= 24'h100000;
        repeat (FAV / 2) @(posedge pclk);
        chk("measured", ia, meas);
        wait_for(1'b1, 24'h140000, FAV * 5);
        rdm(cfw_pkg::ADDR_ACCUMULATION_MODE_REGISTER, 32'h80, 32'h80);
        repeat (SAV + 20) @(posedge pclk);
        rdm(cfw_pkg::ADDR_IRQST1, 32'h20, 32'h20);
        bus(1'b1, cfw_pkg::ADDR_IRQEN1, 32'h20);
        wait_for(1'b0, 24'h1, 8);
        bus(1'b1, cfw_pkg::ADDR_IRQST1, 32'h20);
        wait_for(1'b0, 24'h0, 8);
        ia <= 24'h148000;
        repeat (FAV * 3) @(posedge pclk);
        chk("measured", ib, meas);
        ia <= 24'h180000;
        wait_for(1'b1, 24'h180000, FAV * 5);
        // Balanced inputs settle a normal state before the sign test
        ib <= 24'h180000;
        repeat (SAV * 3) @(posedge pclk);
        bus(1'b1, cfw_pkg::ADDR_IRQST1, 32'h20);
        ia <= 24'h100000;
        ib <= 24'h0E0000;
        repeat (SAV * 2) @(posedge pclk);
        rdm(cfw_pkg::ADDR_IRQST1, 32'h20, 32'h20);
        chk("measured", ia, meas);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        presetn = 1'b0;
        ia = 24'h0;
        ib = 24'h0;
        vs = 24'h0;
        num_errors = 0;
        comparisons = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_rate();
        t_latch();
        t_force();
        t_fault();
        final_report(1'b0);
    end
endmodule
bind cfw_top cfw_top_chk #(.FAULT_AVG_CYC(FAULT_AVG_CYC),
    .SIGN_AVG_CYC(SIGN_AVG_CYC), .BASE_DIV(BASE_DIV), .V_MIN(V_MIN))
    cfw_top_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .first_current_input(first_current_input),
    .second_current_input(second_current_input),
    .voltage_sample(voltage_sample), .measured_current(measured_current),
    .irq(irq));
